// ==== src/acr_config_regs.v ====
// acr_config_regs.v: serial-programmed configuration bank for a sampling converter,
// covering sync/power-down pin routing, reference and clock selection, input mode,
// delay loop, auto-zero, bitmap load strobe and the fixed test pattern value.
// assumes: serial port and pins arrive asynchronous to i_mclk, i_mclk far faster
// than the serial clock; i_ce low freezes every flip-flop.
`timescale 1ns/1ps
`include "acr_defines.vh"

module acr_config_regs #(
  parameter FAST_GRADE = 0                        // 1 selects the fastest speed grade
) (
  input  wire        i_mclk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire        i_spi_sclk,
  input  wire        i_spi_sen_n,
  input  wire        i_spi_sdi,
  input  wire        i_shared_align_powerdown_pin,
  input  wire        i_reference_buffer_pin,
  output reg         o_spi_sdo,
  output reg         o_spi_sdo_oe,
  output reg         o_global_powerdown,
  output reg         o_align_pulse,
  output reg  [1:0]  o_reference_choice,
  output reg         o_single_ended_clock,
  output reg         o_diff_clock_buffer_pd,
  output reg         o_single_ended_input,
  output reg         o_half_period_sampling,
  output reg         o_auto_zero,
  output reg         o_bitmap_load_pulse,
  output reg  [17:0] o_fixed_pattern_value,
  output reg  [2:0]  o_test_pattern_select
);

  // slow grades come out of reset with auto-zero on, the fastest grade with it off
  localparam AZ_RESET = (FAST_GRADE != 0) ? `ACR_RST_AZ_FAST : `ACR_RST_AZ_SLOW;

  // ==================================================
  // pin synchronisers: three stages, a change counts once stages two and three agree
  // pad order in every stage: bit 0 sclk, 1 sen_n, 2 sdi, 3 shared pin, 4 reference pin
  // stages reset to the pads' idle levels, so release of reset shows no false edge
  // the filtered level lags a pad by three mclk edges; a one-cycle glitch never reaches it
  // i_ce low freezes the stages too, so a frame sent while frozen is lost
  reg [4:0] s1_ff;
  reg [4:0] s2_ff;
  reg [4:0] s3_ff;
  reg [4:0] lvl_ff;
  reg [4:0] nxt_lvl;
  integer   k;

  // pads gathered in stage order
  wire [4:0] pad_now = {i_reference_buffer_pin, i_shared_align_powerdown_pin, i_spi_sdi, i_spi_sen_n, i_spi_sclk};

  // only stage two reads stage one
  // lvl_ff holds the filtered level that edge detection compares against
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff  <= `ACR_PAD_IDLE;
      s2_ff  <= `ACR_PAD_IDLE;
      s3_ff  <= `ACR_PAD_IDLE;
      lvl_ff <= `ACR_PAD_IDLE;                    // sen idles high, the rest low
    end else if (i_ce) begin
      s1_ff  <= pad_now;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  // filter: hold the old level while the two late stages disagree
  // a pad that flips every cycle never settles, so its level simply holds
  // k is only a loop index; no state is kept in it
  always @* begin
    nxt_lvl = lvl_ff;
    for (k = 0; k < 5; k = k + 1) begin
      if (s2_ff[k] == s3_ff[k]) begin
        nxt_lvl[k] = s3_ff[k];
      end
    end
  end

  // edges compare the next level with the current one, a cycle ahead of lvl_ff
  wire sclk_rise = nxt_lvl[0] & ~lvl_ff[0];
  wire sclk_fall = ~nxt_lvl[0] & lvl_ff[0];
  wire sen_n     = nxt_lvl[1];
  wire sdi       = nxt_lvl[2];
  wire pin_sync  = nxt_lvl[3];
  wire pin_rise  = nxt_lvl[3] & ~lvl_ff[3];
  wire ref_pin   = nxt_lvl[4];

  // ==================================================
  // serial slave: frame of read flag, address, data
  // frame: bit 15 read flag, bits 14:8 address, bits 7:0 data, msb first
  // the 8th rising sclk closes the header; a read loads out_ff from the mux then
  // read data leaves on each falling sclk after the header, so the host samples at rise
  // the 16th rising sclk ends the frame; sen_n high at any point aborts it
  // limitation: each sclk level must last at least two mclk cycles to be seen
  // sr_ff is not cleared at frame start: stale bits shift out before they are used
  reg  [4:0]  cnt_ff;
  reg  [15:0] sr_ff;
  reg  [7:0]  out_ff;
  reg         rd_ff;
  wire [15:0] sr_next = {sr_ff[14:0], sdi};
  reg  [7:0]  rdata;

  // register storage
  // every mapped byte is stored whole; must-be-zero bits read back as written
  // unmapped addresses: writes vanish and reads return zero
  reg  [7:0]  sync_ref_ff;
  reg  [7:0]  input_samp_ff;
  reg  [7:0]  bitmap_ff;
  reg  [7:0]  pat_low_ff;
  reg  [7:0]  pat_mid_ff;
  reg  [7:0]  pat_high_ff;

  // readback mux, unmapped addresses read zero
  always @* begin
    case (sr_next[6:0])
      `ACR_ADDR_SYNC_REF:    rdata = sync_ref_ff;
      `ACR_ADDR_INPUT_SAMP:  rdata = input_samp_ff;
      `ACR_ADDR_BITMAP_LOAD: rdata = bitmap_ff;
      `ACR_ADDR_PAT_LOW:     rdata = pat_low_ff;
      `ACR_ADDR_PAT_MID:     rdata = pat_mid_ff;
      `ACR_ADDR_PAT_HIGH:    rdata = pat_high_ff;
      default:               rdata = `ACR_RST_BYTE;
    endcase
  end

  // header and frame ends count filtered sclk edges, never the raw pad
  wire hdr_done  = ~sen_n & sclk_rise & (cnt_ff == `ACR_HDR_BITS - `ACR_CNT_ONE);
  wire frame_end = ~sen_n & sclk_rise & (cnt_ff == `ACR_FRAME_BITS - `ACR_CNT_ONE);
  wire wr_go     = frame_end & ~sr_ff[14];        // read flag sits at bit 14 until the last shift
  wire [6:0] wr_addr = sr_ff[13:7];
  wire [7:0] wr_data = sr_next[7:0];

  // shift in on rising sclk, read data leaves on falling sclk
  // oe falls at the 16th rise, so the line is free before sen_n goes high
  // rd_ff keeps oe and shifting confined to the data half of a read frame
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff       <= 5'h00;
      sr_ff        <= 16'h0000;
      out_ff       <= 8'h00;
      rd_ff        <= 1'b0;
      o_spi_sdo    <= 1'b0;
      o_spi_sdo_oe <= 1'b0;
    end else if (i_ce) begin
      if (sen_n) begin
        cnt_ff       <= 5'h00;
        rd_ff        <= 1'b0;
        o_spi_sdo_oe <= 1'b0;
      end else begin
        if (sclk_rise) begin
          sr_ff  <= sr_next;
          cnt_ff <= frame_end ? 5'h00 : cnt_ff + `ACR_CNT_ONE;
        end
        if (hdr_done) begin
          rd_ff  <= sr_ff[6];                     // read flag is the frame's first bit
          out_ff <= rdata;
        end
        if (frame_end) begin
          rd_ff        <= 1'b0;
          o_spi_sdo_oe <= 1'b0;
        end else if (sclk_fall && rd_ff) begin
          o_spi_sdo    <= out_ff[7];
          o_spi_sdo_oe <= 1'b1;
          out_ff       <= {out_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ==================================================
  // register writes; a completed bitmap load returns the bank to reset values
  // the load fires on the strobe's fall from 1 to 0, one cycle after the 0 lands
  // the strobe register is not wiped by its own load, so it reads back the 0 last written
  // trade-off: the load wins over a write in the same cycle; hosts space frames anyway
  // the strobe bit itself sits in bitmap_ff and is written on its own path
  reg  strobe_d_ff;
  reg  trig_d_ff;
  wire load_done = strobe_d_ff & ~bitmap_ff[`ACR_B_BITMAP_STROBE];

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync_ref_ff   <= `ACR_RST_BYTE;
      input_samp_ff <= {7'h00, AZ_RESET[0]};
      bitmap_ff     <= `ACR_RST_BYTE;
      pat_low_ff    <= `ACR_RST_BYTE;
      pat_mid_ff    <= `ACR_RST_BYTE;
      pat_high_ff   <= `ACR_RST_BYTE;
    end else if (i_ce) begin
      if (load_done) begin
        // wipes what was written before the load; a write landing now is lost too
        sync_ref_ff   <= `ACR_RST_BYTE;
        input_samp_ff <= {7'h00, AZ_RESET[0]};
        pat_low_ff    <= `ACR_RST_BYTE;
        pat_mid_ff    <= `ACR_RST_BYTE;
        pat_high_ff   <= `ACR_RST_BYTE;
      end else if (wr_go) begin
        // pattern bytes land as written; outputs pick them up one cycle later
        case (wr_addr)
          `ACR_ADDR_SYNC_REF:   sync_ref_ff   <= wr_data;
          `ACR_ADDR_INPUT_SAMP: input_samp_ff <= wr_data;
          `ACR_ADDR_PAT_LOW:    pat_low_ff    <= wr_data;
          `ACR_ADDR_PAT_MID:    pat_mid_ff    <= wr_data;
          `ACR_ADDR_PAT_HIGH:   pat_high_ff   <= wr_data;
          default: ;
        endcase
      end
      if (wr_go && wr_addr == `ACR_ADDR_BITMAP_LOAD) begin
        bitmap_ff <= wr_data;
      end
    end
  end

  // ==================================================
  // alignment and power-down from pin or register trigger
  // the pin only aligns on a rising edge, so a pin held high issues one command
  // register sync allowed: the pin no longer aligns; powerdown follows the pin only while pin select is 0
  // trig_d_ff follows the stored bit, so a trigger left at 1 stays silent
  // trig_up needs allow in the same cycle; enabling with the trigger already set is silent
  // a load that clears the trigger resets the edge history with it
  wire pin_sel  = sync_ref_ff[`ACR_B_PIN_SELECT];
  wire allow    = sync_ref_ff[`ACR_B_SYNC_ALLOW];
  wire trig     = sync_ref_ff[`ACR_B_SYNC_TRIGGER];
  wire trig_up  = trig & ~trig_d_ff & allow;
  wire pin_algn = pin_sel & ~allow & pin_rise;

  // align and load are one-cycle pulses; downstream must catch them on this clock
  // powerdown is a level, one flop behind the filtered pin
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      strobe_d_ff         <= 1'b0;
      trig_d_ff           <= 1'b0;
      o_global_powerdown  <= 1'b0;
      o_align_pulse       <= 1'b0;
      o_bitmap_load_pulse <= 1'b0;
    end else if (i_ce) begin
      strobe_d_ff         <= bitmap_ff[`ACR_B_BITMAP_STROBE];
      trig_d_ff           <= trig;                 // the bit itself never self clears
      o_global_powerdown  <= ~pin_sel & pin_sync;
      o_align_pulse       <= trig_up | pin_algn;
      o_bitmap_load_pulse <= load_done;
    end
  end

  // ==================================================
  // static configuration outputs, registered
  // override 0: the reference pin decides, pin high picks the buffered external reference
  // override 0 also keeps the differential clock input, whatever bit 0 holds
  // all outputs settle one cycle after the register they follow
  // fixed pattern value: high bits from pattern_value_high, then mid, then low
  wire       ovr     = sync_ref_ff[`ACR_B_REF_OVERRIDE];
  wire [1:0] ref_fld = sync_ref_ff[`ACR_F_REF_HI:`ACR_F_REF_LO];

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reference_choice     <= `ACR_REF_INTERNAL;
      o_single_ended_clock   <= 1'b0;
      o_diff_clock_buffer_pd <= 1'b0;
      o_single_ended_input   <= 1'b0;
      o_half_period_sampling <= 1'b0;
      o_auto_zero            <= AZ_RESET[0];
      o_fixed_pattern_value  <= 18'h00000;
      o_test_pattern_select  <= 3'h0;
    end else if (i_ce) begin
      if (!ovr) begin
        o_reference_choice <= ref_pin ? `ACR_REF_EXT_BUFFERED : `ACR_REF_INTERNAL;
      end else begin
        // unused code 11 keeps the last valid choice
        case (ref_fld)
          `ACR_REF_INTERNAL:     o_reference_choice <= `ACR_REF_INTERNAL;
          `ACR_REF_EXT_BUFFERED: o_reference_choice <= `ACR_REF_EXT_BUFFERED;
          `ACR_REF_EXTERNAL:     o_reference_choice <= `ACR_REF_EXTERNAL;
          default:               o_reference_choice <= o_reference_choice;
        endcase
      end
      o_single_ended_clock   <= ovr & sync_ref_ff[`ACR_B_SE_CLOCK];
      o_diff_clock_buffer_pd <= ovr & sync_ref_ff[`ACR_B_SE_CLOCK];
      o_single_ended_input   <= input_samp_ff[`ACR_B_SE_INPUT];
      o_half_period_sampling <= input_samp_ff[`ACR_B_DELAY_LOOP_PD];
      o_auto_zero            <= input_samp_ff[`ACR_B_AUTO_ZERO];
      o_fixed_pattern_value  <= {pat_high_ff[`ACR_F_PATHI_HI:`ACR_F_PATHI_LO],
                                 pat_mid_ff, pat_low_ff};
      o_test_pattern_select  <= pat_high_ff[`ACR_F_TPSEL_HI:`ACR_F_TPSEL_LO];
    end
  end

endmodule // acr_config_regs

// ==== src/acr_defines.vh ====
// acr_defines.vh: constants for the converter sync/reference configuration bank
// assumes: included by acr_config_regs.v only, definitions only
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// ==================================================
// register addresses (7-bit serial address field)
`define ACR_ADDR_SYNC_REF      7'h0E
`define ACR_ADDR_INPUT_SAMP    7'h11
`define ACR_ADDR_BITMAP_LOAD   7'h13
`define ACR_ADDR_PAT_LOW       7'h14
`define ACR_ADDR_PAT_MID       7'h15
`define ACR_ADDR_PAT_HIGH      7'h16

// ==================================================
// reset values
`define ACR_RST_BYTE           8'h00
`define ACR_RST_AZ_SLOW        1'h1
`define ACR_RST_AZ_FAST        1'h0
// synchroniser idle levels: only the active-low serial enable rests high
`define ACR_PAD_IDLE           5'h02

// ==================================================
// sync_and_reference_control fields
`define ACR_B_PIN_SELECT       7
`define ACR_B_SYNC_TRIGGER     6
`define ACR_B_SYNC_ALLOW       5
`define ACR_B_REF_OVERRIDE     3
`define ACR_F_REF_HI           2
`define ACR_F_REF_LO           1
`define ACR_B_SE_CLOCK         0

// reference choice encodings
`define ACR_REF_INTERNAL       2'h0
`define ACR_REF_EXT_BUFFERED   2'h1
`define ACR_REF_EXTERNAL       2'h2

// ==================================================
// input_and_sampling_control fields
`define ACR_B_SE_INPUT         5
`define ACR_B_DELAY_LOOP_PD    2
`define ACR_B_AUTO_ZERO        0

// bitmap_load_control field
`define ACR_B_BITMAP_STROBE    0

// pattern_select_and_value_high fields
`define ACR_F_TPSEL_HI         4
`define ACR_F_TPSEL_LO         2
`define ACR_F_PATHI_HI         1
`define ACR_F_PATHI_LO         0

// ==================================================
// serial frame: 1 read flag, 7 address bits, 8 data bits, msb first
`define ACR_FRAME_BITS         5'h10
`define ACR_HDR_BITS           5'h08
`define ACR_CNT_ONE            5'h01

`endif

// ==== tb/acr_config_regs_assertions.sv ====
// checker for the config bank outputs
// assumes: bound to acr_config_regs, one clock, async reset
`timescale 1ns/1ps
module acr_config_regs_assertions #(
  parameter FAST_GRADE = 0
) (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_shared_align_powerdown_pin,
  input wire logic        o_global_powerdown,
  input wire logic        o_align_pulse,
  input wire logic [1:0]  o_reference_choice,
  input wire logic        o_single_ended_clock,
  input wire logic        o_diff_clock_buffer_pd,
  input wire logic        o_auto_zero,
  input wire logic        o_single_ended_input,
  input wire logic        o_bitmap_load_pulse,
  input wire logic [17:0] o_fixed_pattern_value,
  input wire logic [2:0]  o_test_pattern_select
);
  logic [5:0] pin_hist_ff;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ==========
  // recent pad history, wide enough to cover the synchroniser lag
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) pin_hist_ff <= 6'h00;
    else pin_hist_ff <= {pin_hist_ff[4:0], i_shared_align_powerdown_pin};
  end
  property p_pd_needs_pin; o_global_powerdown |-> (|pin_hist_ff); endproperty
  a_pd_needs_pin: assert property (p_pd_needs_pin) else $error("powerdown without pin");
  property p_align_once; o_align_pulse |=> !o_align_pulse; endproperty
  a_align_once: assert property (p_align_once) else $error("align pulse too long");
  property p_load_once; o_bitmap_load_pulse |=> !o_bitmap_load_pulse; endproperty
  a_load_once: assert property (p_load_once) else $error("load pulse too long");
  property p_load_clr_pat; o_bitmap_load_pulse |-> ##[0:2] (o_fixed_pattern_value == 18'h00000); endproperty
  a_load_clr_pat: assert property (p_load_clr_pat) else $error("pattern kept");
  property p_load_clr_sel; o_bitmap_load_pulse |-> ##[0:2] (o_test_pattern_select == 3'h0 && !o_single_ended_input); endproperty
  a_load_clr_sel: assert property (p_load_clr_sel) else $error("config kept");
  property p_clk_pair; o_single_ended_clock == o_diff_clock_buffer_pd; endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock buffer mismatch");
  property p_ref_code; o_reference_choice != 2'h3; endproperty
  a_ref_code: assert property (p_ref_code) else $error("unused reference code");
  property p_az_reset; $fell(i_rst) |-> o_auto_zero == (FAST_GRADE == 0); endproperty
  a_az_reset: assert property (@(posedge i_mclk) p_az_reset) else $error("auto zero reset");
endmodule // acr_config_regs_assertions
bind acr_config_regs acr_config_regs_assertions #(.FAST_GRADE(FAST_GRADE)) u_chk (.i_mclk, .i_rst,
  .i_shared_align_powerdown_pin, .o_global_powerdown, .o_align_pulse, .o_reference_choice, .o_single_ended_clock,
  .o_diff_clock_buffer_pd, .o_auto_zero, .o_single_ended_input, .o_bitmap_load_pulse, .o_fixed_pattern_value,
  .o_test_pattern_select);

// ==== tb/acr_spi_host.sv ====
// host side serial master model
// assumes: mclk 100 MHz; every sclk level lasts 8 mclk
`timescale 1ns/1ps
module acr_spi_host (
  input  wire logic i_mclk,
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_sen_n,
  output logic      o_sdi
);
  // idle: clock parked low, frame closed
  initial begin
    o_sclk = 1'b0;
    o_sen_n = 1'b1;
    o_sdi = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge i_mclk);
  endtask
  // one 16-bit frame, msb first; read data sampled at sclk rise
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    o_sen_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_sdi = f[i];
      half();
      o_sclk = 1'b1;
      if (i < 8) q = {q[6:0], i_sdo};
      half();
      o_sclk = 1'b0;
    end
    half();
    o_sen_n = 1'b1;
    o_sdi = ~o_sdi; // released line must not keep its last value
    half();
  endtask
endmodule // acr_spi_host

// ==== tb/tb.sv ====
// self-checking bench for the config bank
// assumes: acr_spi_host model; inputs change on falling mclk
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0, i_rst = 1'b1, pin = 1'b0, refpin = 1'b0, pd_seen;
  wire sclk, sen_n, sdi, sdo, sdo_oe, pd, al, sec, dpd, sei, hps, az, bl;
  wire [1:0] rc;
  wire [17:0] pv;
  wire [2:0] tps;
  int failures = 0, tests_run = 0, cycles = 0, al_cnt = 0, bl_cnt = 0, oe_cnt = 0, a;
  logic [7:0] q;
  logic [6:0] ra [6] = '{7'h0E, 7'h13, 7'h14, 7'h15, 7'h16, 7'h20};
  acr_spi_host host (.i_mclk(i_mclk), .i_sdo(sdo), .o_sclk(sclk), .o_sen_n(sen_n), .o_sdi(sdi));
  acr_config_regs dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .i_spi_sclk(sclk), .i_spi_sen_n(sen_n),
    .i_spi_sdi(sdi), .i_shared_align_powerdown_pin(pin), .i_reference_buffer_pin(refpin), .o_spi_sdo(sdo),
    .o_spi_sdo_oe(sdo_oe), .o_global_powerdown(pd), .o_align_pulse(al), .o_reference_choice(rc),
    .o_single_ended_clock(sec), .o_diff_clock_buffer_pd(dpd), .o_single_ended_input(sei),
    .o_half_period_sampling(hps), .o_auto_zero(az), .o_bitmap_load_pulse(bl), .o_fixed_pattern_value(pv),
    .o_test_pattern_select(tps));
  initial forever #5 i_mclk = ~i_mclk;
  // ==========
  // pulse counters and hang guard, sampled at the falling edge where outputs have settled
  always @(negedge i_mclk) begin
    cycles++;
    if (al === 1'b1) al_cnt++;
    if (bl === 1'b1) bl_cnt++;
    if (sdo_oe === 1'b1) oe_cnt++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    int n;
    n = oe_cnt;
    host.xfer(1'b0, ad, d, q);
    chk(18'(oe_cnt - n), 18'h0);
  endtask
  task automatic rd(input logic [6:0] ad, input logic [7:0] e);
    int n;
    n = oe_cnt;
    host.xfer(1'b1, ad, 8'h00, q);
    chk(q, e);
    chk(18'(oe_cnt != n), 18'h1);
    chk(sdo_oe, 1'b0);
  endtask
  // pad high long enough to pass the synchroniser, sampling powerdown
  task automatic pin_pulse();
    a = al_cnt;
    pin = 1'b1;
    repeat (10) @(negedge i_mclk);
    pd_seen = pd;
    pin = 1'b0;
    repeat (10) @(negedge i_mclk);
  endtask
  // ==========
  task automatic t_reset();
    chk(az, 1'b1);
    rd(7'h11, 8'h01);
    foreach (ra[i]) rd(ra[i], 8'h00);
  endtask
  task automatic t_pattern();
    wr(7'h14, 8'hA5);
    wr(7'h15, 8'h3C);
    wr(7'h16, 8'h1E);
    chk(pv, 18'h23CA5);
    chk(tps, 3'h7);
    rd(7'h16, 8'h1E);
  endtask
  task automatic t_ref();
    for (int c = 0; c < 3; c++) begin
      wr(7'h0E, {5'h01, c[1:0], 1'b1});
      chk(rc, c[1:0]);
      chk({sec, dpd}, 2'h3);
    end
    wr(7'h0E, 8'h0F);
    chk(rc, 2'h2);
    wr(7'h0E, 8'h00);
    refpin = 1'b1;
    repeat (10) @(negedge i_mclk);
    chk({rc, sec}, 3'h2);
    refpin = 1'b0;
    repeat (10) @(negedge i_mclk);
    chk(rc, 2'h0);
  endtask
  task automatic t_input();
    wr(7'h11, 8'h25);
    chk({sei, hps, az}, 3'h7);
    wr(7'h11, 8'h00);
    chk({sei, hps, az}, 3'h0);
  endtask
  task automatic t_sync();
    wr(7'h0E, 8'h80);
    pin_pulse();
    chk({pd_seen, 17'(al_cnt - a)}, 18'h00001);
    wr(7'h0E, 8'h00);
    pin_pulse();
    chk({pd_seen, 17'(al_cnt - a)}, 18'h20000);
    wr(7'h0E, 8'hA0);
    pin_pulse();
    chk(18'(al_cnt - a), 18'h0);
    wr(7'h0E, 8'hE0);
    wr(7'h0E, 8'hE0);
    chk(18'(al_cnt - a), 18'h1);
    rd(7'h0E, 8'hE0);
    wr(7'h0E, 8'h00);
    wr(7'h0E, 8'h40);
    chk(18'(al_cnt - a), 18'h1);
    wr(7'h0E, 8'h00);
  endtask
  task automatic t_bitmap();
    wr(7'h14, 8'hFF);
    wr(7'h11, 8'h24);
    a = bl_cnt;
    wr(7'h13, 8'h01);
    chk(18'(bl_cnt - a), 18'h0);
    wr(7'h13, 8'h00);
    chk(18'(bl_cnt - a), 18'h1);
    chk(pv, 18'h00000);
    chk({tps, sei, hps, az}, 18'h1);
    rd(7'h13, 8'h00);
  endtask
  // ==========
  initial begin
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    t_reset();
    t_pattern();
    t_ref();
    t_input();
    t_sync();
    t_bitmap();
    report_and_stop();
  end
endmodule // tb
